// ---- hdl/mhap_regs.svh ----
/*
  Offsets, field positions, codes and timing counts of the motion host access port.
  Assumes it is included by its bare name from the design files.
*/
`ifndef MHAP_REGS_SVH
`define MHAP_REGS_SVH
// ------------------------------------------------------------
// parallel byte offsets inside one axis window (low two address bits)
// ------------------------------------------------------------
`define MHAP_OFS_CMD    2'h0
`define MHAP_OFS_W_LO   2'h1
`define MHAP_OFS_W_MID  2'h2
`define MHAP_OFS_W_HI   2'h3
// ------------------------------------------------------------
// serial selection byte layout: axis [3:0], type [5:4], device [7:6]
// ------------------------------------------------------------
`define MHAP_SEL_AXIS_LSB 0
`define MHAP_SEL_TYPE_LSB 4
`define MHAP_SEL_DEV_LSB  6
// ------------------------------------------------------------
// command codes and timing counts
// ------------------------------------------------------------
`define MHAP_REGSEL_HI  4'hb
`define MHAP_SI_A       4'he
`define MHAP_SI_B       4'hf
`define MHAP_BUSY_CYC   3'h4
`define MHAP_STRAP_CYC  2'h3
`endif

// ---- hdl/mhap_pkg.sv ----
/*
  Types of the motion host access port.
  Assumes nothing of its surroundings.
*/
package mhap_pkg;
  // serial access type, in selection-field order
  typedef enum logic [1:0] {ACC_WR, ACC_RD, ACC_PORT, ACC_MAIN_STATUS} mhap_acc_t;
  // serial frame walker
  typedef enum logic [2:0] {SER_SEL, SER_CMD, SER_DATA, SER_SI, SER_RD, SER_SKIP} mhap_ser_t;
endpackage : mhap_pkg

// ---- hdl/mhap_link_if.sv ----
/*
  Byte-level link between the serial receiver and the access core.
  Assumes both ends run on the reference clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface mhap_link_if;
  logic       byte_vld;  // one-cycle pulse, byte complete
  logic [7:0] byte_dat;  // received byte, msb first on the wire
  logic [2:0] bit_cnt;   // bits of the current byte so far
  logic       ss_low;    // frame active
  logic       ss_rise;   // one-cycle pulse, frame end
  logic       sck_fall;  // one-cycle pulse, falling serial clock
  modport rx   (output byte_vld, byte_dat, bit_cnt, ss_low, ss_rise, sck_fall);
  modport core (input  byte_vld, byte_dat, bit_cnt, ss_low, ss_rise, sck_fall);
endinterface : mhap_link_if
`default_nettype wire

// ---- hdl/mhap_spi_rx.sv ----
/*
  Serial receiver: synchronises the serial pins to the reference clock and
  assembles bytes. Assumes the serial clock runs at most half the sample rate.
*/
`timescale 1ns/1ns
`default_nettype none
module mhap_spi_rx (
  input  wire logic clk,    // reference clock
  input  wire logic rst_b,  // async reset, active low
  input  wire logic sck,    // serial clock pin
  input  wire logic mosi,   // serial data in pin
  input  wire logic ss_b,   // slave select pin, active low
  input  wire logic en,     // serial interface chosen
  mhap_link_if.rx   lk      // byte link to the core
);
  localparam logic [2:0] RST_V = 3'h4;
  wire  [2:0] raw = {ss_b, mosi, sck};
  logic [2:0] s1_r, s2_r;
  logic       sck_d_r, ss_d_r;
  logic [6:0] sh_r;
  logic [2:0] cnt_r;
  logic       vld_r;
  logic [7:0] dat_r;

  // ------------------------------------------------------------
  // two-stage synchronisers, one per pin
  // ------------------------------------------------------------
  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        s1_r[i] <= RST_V[i];
        s2_r[i] <= RST_V[i];
      end else begin
        s1_r[i] <= raw[i];
        s2_r[i] <= s1_r[i];
      end
    end
  end

  // edge detection only looks at the second stage
  wire rise   = s2_r[0] & ~sck_d_r;
  wire fall   = ~s2_r[0] & sck_d_r;
  wire ss_act = ~s2_r[2] & en;

  // ------------------------------------------------------------
  // sample on rising serial clock, bit count restarts with each frame
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_d_r <= 1'b0;
      ss_d_r  <= 1'b1;
      sh_r    <= 7'h00;
      cnt_r   <= 3'h0;
      vld_r   <= 1'b0;
      dat_r   <= 8'h00;
    end else begin
      sck_d_r <= s2_r[0];
      ss_d_r  <= s2_r[2];
      vld_r   <= ss_act & rise & (cnt_r == 3'h7);
      if (!ss_act) begin
        cnt_r <= 3'h0;
      end else if (rise) begin
        sh_r  <= {sh_r[5:0], s2_r[1]};
        cnt_r <= cnt_r + 3'h1;
        if (cnt_r == 3'h7) begin
          dat_r <= {sh_r, s2_r[1]};
        end
      end
    end
  end

  assign lk.byte_vld = vld_r;
  assign lk.byte_dat = dat_r;
  assign lk.bit_cnt  = cnt_r;
  assign lk.ss_low   = ss_act;
  assign lk.ss_rise  = en & s2_r[2] & ~ss_d_r;
  assign lk.sck_fall = ss_act & fall;
endmodule : mhap_spi_rx
`default_nettype wire

// ---- hdl/mhap_top.sv ----
/*
  Host access port of a multi-axis pulse controller: parallel byte bus with
  wait request, or four-wire serial link, chosen by a strap at reset.
  Assumes the axis core takes one-cycle strobes and offers status and the
  selected register value per axis on the reference clock.
*/
// Notes on behaviour
// - each axis owns four byte addresses on the parallel bus
// - offset 0 writes the command buffer, reads main status
// - offsets 1..3 fill write staging bytes, read back read-copy bytes
// - writing the low staging byte commits all 24 bits to the selected register
// - read copy mirrors the value of the selected register
// - upper two address bits pick the axis; missing pins are masked
// - after command or low-byte write, further accesses get wait request low
// - after a register-selection command only reads are stalled
// - serial frames are whole bytes; output undriven during header bytes
// - set axis bits select axes; all zero selects the first axis
// - absent axes: writes dropped, reads return zero
// - type field picks write, read, port status or main status access
// - only a matching device number answers; otherwise input ignored
// - two-byte command write takes effect at slave select rise
// - selected axes take the same command at the same moment
// - register write: three bytes per axis, committed at slave select rise
// - data split on 24-bit words; single axis may omit upper bytes
// - single-instance registers ignore axis bits, later bytes discarded
// - single-instance write takes effect right after the third byte
// - serial timing is clock-idle-low or -high, sampled on rising edges
// - write and read strobes both low at reset choose serial mode
`timescale 1ns/1ns
`default_nettype none
`include "mhap_regs.svh"
module mhap_top #(
  parameter int N_AXES = 4
) (
  input  wire logic                clk,           // reference clock, 25 MHz
  input  wire logic                rst_b,         // async reset, active low
  input  wire logic                cs_b,          // chip select or slave select
  input  wire logic                wr_b,          // write strobe, strap at reset
  input  wire logic                rd_b,          // read strobe, strap at reset
  input  wire logic [3:0]          addr_i,        // address; [1:0] device number in serial
  input  wire logic [7:0]          d_i,           // data bus in; [6] sck, [7] mosi
  output logic      [7:0]          d_o,           // data bus out
  output logic                     d_oe,          // data bus drive enable
  output logic                     wrq_miso_o,    // wait_request_n or serial out
  output logic                     wrq_miso_oe,   // drive enable of that pin
  output logic                     serial_mode,   // serial interface chosen
  output logic [N_AXES-1:0]        cmd_stb_o,     // command strobe per axis
  output logic [7:0]               cmd_dat_o,     // command byte
  output logic [N_AXES*4-1:0]      reg_sel_o,     // selected register per axis
  output logic [N_AXES-1:0]        reg_wr_stb_o,  // register write strobe per axis
  output logic [N_AXES*24-1:0]     reg_wr_dat_o,  // staged register data per axis
  output logic                     si_wr_stb_o,   // single-instance write strobe
  output logic                     si_wr_sel_o,   // 0 reg a, 1 reg b
  output logic [7:0]               si_wr_dat_o,   // single-instance data
  input  wire logic [N_AXES*8-1:0] main_status_i, // main status per axis
  input  wire logic [N_AXES*24-1:0] reg_val_i     // selected register value per axis
);
  localparam logic [3:0] EXIST = 4'((1 << N_AXES) - 1);
  localparam logic [1:0] AMASK = (N_AXES > 2) ? 2'h3 : ((N_AXES > 1) ? 2'h1 : 2'h0);

  function automatic logic [1:0] low_idx(input logic [3:0] m);
    low_idx = m[0] ? 2'h0 : (m[1] ? 2'h1 : (m[2] ? 2'h2 : 2'h3));
  endfunction : low_idx

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  localparam logic [14:0] PIN_RST = 15'h7000;
  wire  [14:0] pin_raw = {cs_b, wr_b, rd_b, addr_i, d_i};
  logic [14:0] p1_r, p2_r;
  for (genvar i = 0; i < 15; i++) begin : g_psync
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        p1_r[i] <= PIN_RST[i];
        p2_r[i] <= PIN_RST[i];
      end else begin
        p1_r[i] <= pin_raw[i];
        p2_r[i] <= p1_r[i];
      end
    end
  end
  wire       cs_s = p2_r[14];
  wire       wr_s = p2_r[13];
  wire       rd_s = p2_r[12];
  wire [3:0] a_s  = p2_r[11:8];
  wire [7:0] d_s  = p2_r[7:0];

  // ------------------------------------------------------------
  // interface strap, caught once the synchronisers hold the reset-time level
  // ------------------------------------------------------------
  logic [1:0] strap_cnt_r;
  logic       ser_mode_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_cnt_r <= 2'h0;
      ser_mode_r  <= 1'b0;
    end else if (strap_cnt_r != `MHAP_STRAP_CYC) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      ser_mode_r  <= ~wr_s & ~rd_s;
    end
  end
  assign serial_mode = ser_mode_r;

  // ------------------------------------------------------------
  // parallel decode
  // ------------------------------------------------------------
  logic       wr_d_r, lo_wr_d_r;
  logic [2:0] busy_cnt_r;
  logic       busy_rd_only_r;
  wire        p_acc     = ~ser_mode_r & ~cs_s & (strap_cnt_r == `MHAP_STRAP_CYC);
  wire [1:0]  p_ax      = a_s[3:2] & AMASK;
  wire [1:0]  p_lo      = a_s[1:0];
  wire        p_busy    = busy_cnt_r != 3'h0;
  wire        p_rd_req  = p_acc & ~rd_s;
  wire        p_wr_req  = p_acc & ~wr_s;
  wire        p_hard    = p_busy & ~busy_rd_only_r;
  wire        p_stall   = (p_busy & p_rd_req) | (p_hard & p_wr_req);
  wire        p_wr_end  = p_acc & wr_s & ~wr_d_r & ~p_hard;
  wire        p_cmd_wr  = p_wr_end & (p_lo == `MHAP_OFS_CMD);
  wire        p_lo_wr   = p_wr_end & (p_lo == `MHAP_OFS_W_LO);
  wire        p_regsel  = d_s[7:4] == `MHAP_REGSEL_HI;
  wire [3:0]  p_ax_oh   = 4'h1 << p_ax;

  // internal procedure timer after a triggering write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_d_r         <= 1'b1;
      lo_wr_d_r      <= 1'b0;
      busy_cnt_r     <= 3'h0;
      busy_rd_only_r <= 1'b0;
    end else begin
      wr_d_r    <= wr_s;
      lo_wr_d_r <= p_lo_wr;
      if (p_cmd_wr | p_lo_wr) begin
        busy_cnt_r     <= `MHAP_BUSY_CYC;
        busy_rd_only_r <= p_cmd_wr & p_regsel;
      end else if (p_busy) begin
        busy_cnt_r <= busy_cnt_r - 3'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // serial frame walker
  // ------------------------------------------------------------
  mhap_link_if lk ();
  mhap_spi_rx u_rx (
    .clk   (clk),
    .rst_b (rst_b),
    .sck   (d_i[6]),
    .mosi  (d_i[7]),
    .ss_b  (cs_b),
    .en    (ser_mode_r),
    .lk    (lk.rx)
  );

  mhap_pkg::mhap_ser_t st_r;
  mhap_pkg::mhap_acc_t acc_r;
  logic [3:0] sel_r, rem_r, got_r;
  logic [1:0] wcnt_r;
  logic [7:0] cmd_r, tx_r;
  logic       cmd_got_r, ld_r;
  wire  [7:0] bd       = lk.byte_dat;
  wire  [3:0] b_field  = bd[`MHAP_SEL_AXIS_LSB +: 4];
  wire  [3:0] b_axes   = (b_field == 4'h0) ? 4'h1 : b_field;
  wire  [1:0] b_type   = bd[`MHAP_SEL_TYPE_LSB +: 2];
  wire        b_dev_ok = bd[`MHAP_SEL_DEV_LSB +: 2] == a_s[1:0];
  wire        bv       = lk.byte_vld & lk.ss_low;
  wire        cmd_si   = (bd[7:4] == `MHAP_REGSEL_HI) &
                         ((bd[3:0] == `MHAP_SI_A) | (bd[3:0] == `MHAP_SI_B));
  wire  [1:0] cur_ax   = low_idx(rem_r);
  wire        rem_any  = |rem_r;
  wire        word3    = (acc_r == mhap_pkg::ACC_WR) | (acc_r == mhap_pkg::ACC_RD);
  wire        w_byte   = bv & (st_r == mhap_pkg::SER_DATA) & rem_any;
  wire        adv      = w_byte | (ld_r & rem_any);
  wire        w_end    = ~word3 | (wcnt_r == 2'h2);

  // state of the frame, byte by byte
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= mhap_pkg::SER_SEL;
    end else if (!lk.ss_low) begin
      st_r <= mhap_pkg::SER_SEL;
    end else if (lk.byte_vld) begin
      case (st_r)
        mhap_pkg::SER_SEL: begin
          if (!b_dev_ok) begin
            st_r <= mhap_pkg::SER_SKIP;
          end else if (!b_type[1]) begin
            st_r <= mhap_pkg::SER_CMD;
          end else begin
            st_r <= mhap_pkg::SER_RD;
          end
        end
        mhap_pkg::SER_CMD: begin
          if (acc_r == mhap_pkg::ACC_RD) begin
            st_r <= mhap_pkg::SER_RD;
          end else if (cmd_si) begin
            st_r <= mhap_pkg::SER_SI;
          end else begin
            st_r <= mhap_pkg::SER_DATA;
          end
        end
        mhap_pkg::SER_SI: st_r <= mhap_pkg::SER_SKIP;
        default: st_r <= st_r;
      endcase
    end
  end

  // header capture and per-axis word pointer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_r     <= mhap_pkg::ACC_WR;
      sel_r     <= 4'h0;
      rem_r     <= 4'h0;
      got_r     <= 4'h0;
      wcnt_r    <= 2'h0;
      cmd_r     <= 8'h00;
      cmd_got_r <= 1'b0;
      ld_r      <= 1'b0;
    end else begin
      ld_r <= bv & (((st_r == mhap_pkg::SER_SEL) & b_dev_ok & b_type[1]) |
                    ((st_r == mhap_pkg::SER_CMD) & (acc_r == mhap_pkg::ACC_RD)) |
                    (st_r == mhap_pkg::SER_RD));
      if (bv & (st_r == mhap_pkg::SER_SEL)) begin
        acc_r     <= mhap_pkg::mhap_acc_t'(b_type);
        sel_r     <= b_axes;
        rem_r     <= b_axes;
        got_r     <= 4'h0;
        wcnt_r    <= 2'h0;
        cmd_got_r <= 1'b0;
      end else if (bv & (st_r == mhap_pkg::SER_CMD)) begin
        cmd_r     <= bd;
        cmd_got_r <= (acc_r == mhap_pkg::ACC_WR) & ~cmd_si;
      end else if (adv) begin
        wcnt_r <= w_end ? 2'h0 : wcnt_r + 2'h1;
        if (w_end) begin
          rem_r[cur_ax] <= 1'b0;
        end
        if (w_byte) begin
          got_r[cur_ax] <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // per-axis staging, selection and read copy
  // ------------------------------------------------------------
  logic [23:0] stage_r [4];
  logic [23:0] copy_r  [4];
  logic [3:0]  rsel_r  [4];
  logic [7:0]  ms      [4];
  wire         s_apply = lk.ss_rise & cmd_got_r;
  wire  [3:0]  s_cmd_ax = s_apply ? (sel_r & EXIST) : 4'h0;
  wire  [3:0]  s_reg_ax = s_apply ? (got_r & EXIST) : 4'h0;
  for (genvar i = 0; i < 4; i++) begin : g_axis
    wire [23:0] val = (i < N_AXES) ? reg_val_i[(i % N_AXES)*24 +: 24] : 24'h0;
    assign ms[i] = (i < N_AXES) ? main_status_i[(i % N_AXES)*8 +: 8] : 8'h00;
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        stage_r[i] <= 24'h0;
        copy_r[i]  <= 24'h0;
        rsel_r[i]  <= 4'h0;
      end else begin
        copy_r[i] <= val;
        if (p_wr_end & (p_ax == 2'(i)) & (p_lo != `MHAP_OFS_CMD)) begin
          stage_r[i][(p_lo - 2'h1)*8 +: 8] <= d_s;
        end else if (bv & (st_r == mhap_pkg::SER_SEL)) begin
          stage_r[i] <= 24'h0;
        end else if (w_byte & (cur_ax == 2'(i))) begin
          stage_r[i][wcnt_r*8 +: 8] <= bd;
        end
        if (p_cmd_wr & p_regsel & (p_ax == 2'(i))) begin
          rsel_r[i] <= d_s[3:0];
        end else if (s_cmd_ax[i] & (cmd_r[7:4] == `MHAP_REGSEL_HI)) begin
          rsel_r[i] <= cmd_r[3:0];
        end
      end
    end
    if (i < N_AXES) begin : g_out
      assign reg_sel_o[i*4 +: 4]     = rsel_r[i];
      assign reg_wr_dat_o[i*24 +: 24] = stage_r[i];
    end
  end

  // ------------------------------------------------------------
  // strobes towards the axis core
  // ------------------------------------------------------------
  logic [3:0] cmd_stb_r, reg_stb_r;
  logic [7:0] cmd_dat_r, si_dat_r, d_o_r;
  logic       si_stb_r, si_sel_r;
  logic [3:0] p_ax_oh_d_r;
  wire  [3:0] cmd_stb_nxt = (p_cmd_wr ? p_ax_oh : 4'h0) | s_cmd_ax;
  wire  [3:0] reg_stb_nxt = (lo_wr_d_r ? (4'h1 << low_idx(p_ax_oh_d_r)) : 4'h0) | s_reg_ax;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_stb_r   <= 4'h0;
      reg_stb_r   <= 4'h0;
      cmd_dat_r   <= 8'h00;
      p_ax_oh_d_r <= 4'h1;
      si_stb_r    <= 1'b0;
      si_sel_r    <= 1'b0;
      si_dat_r    <= 8'h00;
    end else begin
      cmd_stb_r   <= cmd_stb_nxt;
      reg_stb_r   <= reg_stb_nxt;
      p_ax_oh_d_r <= p_ax_oh;
      if (p_cmd_wr) begin
        cmd_dat_r <= d_s;
      end else if (s_apply) begin
        cmd_dat_r <= cmd_r;
      end
      si_stb_r <= bv & (st_r == mhap_pkg::SER_SI);
      if (bv & (st_r == mhap_pkg::SER_SI)) begin
        si_sel_r <= cmd_r[3:0] == `MHAP_SI_B;
        si_dat_r <= bd;
      end
    end
  end
  assign cmd_stb_o    = cmd_stb_r[N_AXES-1:0];
  assign cmd_dat_o    = cmd_dat_r;
  assign reg_wr_stb_o = reg_stb_r[N_AXES-1:0];
  assign si_wr_stb_o  = si_stb_r;
  assign si_wr_sel_o  = si_sel_r;
  assign si_wr_dat_o  = si_dat_r;

  // ------------------------------------------------------------
  // read paths: parallel data bus and serial shifter
  // ------------------------------------------------------------
  wire       cur_ok  = rem_any & EXIST[cur_ax];
  wire [7:0] s_byte  = !cur_ok ? 8'h00 :
                       (acc_r == mhap_pkg::ACC_MAIN_STATUS) ? ms[cur_ax] :
                       (acc_r == mhap_pkg::ACC_RD) ? copy_r[cur_ax][wcnt_r*8 +: 8] : 8'h00;
  wire [7:0] p_byte  = (p_lo == `MHAP_OFS_CMD) ? ms[p_ax] :
                       copy_r[p_ax][(p_lo - 2'h1)*8 +: 8];
  // shift out on falling serial clock so data is steady at the rising edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_r  <= 8'h00;
      d_o_r <= 8'h00;
    end else begin
      d_o_r <= p_byte;
      if (ld_r) begin
        tx_r <= s_byte;
      end else if (lk.sck_fall & (lk.bit_cnt != 3'h0)) begin
        tx_r <= {tx_r[6:0], 1'b0};
      end
    end
  end
  wire miso_oe = lk.ss_low & (st_r == mhap_pkg::SER_RD);
  assign d_o         = d_o_r;
  assign d_oe        = p_rd_req;
  assign wrq_miso_o  = ser_mode_r ? tx_r[7] : ~p_stall;
  assign wrq_miso_oe = ser_mode_r ? miso_oe : 1'b1;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_WAIT_HARD: assert property (p_hard & p_acc & (~rd_s | ~wr_s) |-> !wrq_miso_o)
    else $error("access during busy not stalled");
  AST_WAIT_RDONLY: assert property (busy_rd_only_r & p_acc & ~wr_s & rd_s |-> wrq_miso_o)
    else $error("write stalled after register selection");
  AST_BUSY_LEN: assert property (p_lo_wr |=> p_busy [*4] ##1 !p_busy)
    else $error("internal procedure length wrong");
  AST_CMD_AX: assert property (p_cmd_wr |=> cmd_stb_r == $past(p_ax_oh) && cmd_dat_r == $past(d_s))
    else $error("command strobe wrong axis or data");
  AST_REG_COMMIT: assert property (p_lo_wr |-> ##2 reg_stb_r == $past(p_ax_oh, 2))
    else $error("register commit missing");
  AST_HDR_HIZ: assert property (ser_mode_r & ((st_r == mhap_pkg::SER_SEL) |
    (st_r == mhap_pkg::SER_CMD)) |-> !wrq_miso_oe)
    else $error("serial output driven in header");
  AST_SS_APPLY: assert property (ser_mode_r & (cmd_stb_r != 4'h0) |-> $past(lk.ss_rise))
    else $error("serial command applied off slave select rise");
  AST_SI_NOW: assert property (bv & (st_r == mhap_pkg::SER_SI) |=> si_stb_r ##1 !si_stb_r)
    else $error("single-instance write not immediate");
  AST_NO_DEV: assert property (bv & (st_r == mhap_pkg::SER_SEL) & !b_dev_ok
    |=> (st_r == mhap_pkg::SER_SKIP) && !wrq_miso_oe)
    else $error("foreign device frame answered");

  COV_P_CMD:   cover property (p_cmd_wr ##[1:8] p_stall);
  COV_S_REG:   cover property (s_reg_ax != 4'h0);
  COV_S_SI:    cover property (si_stb_r);
  COV_S_READ:  cover property (miso_oe & lk.sck_fall);
endmodule : mhap_top
`default_nettype wire

// ---- tb/mhap_host_model.sv ----
/* Host side of the serial link: drives clock, data and slave select.
   Assumes the bench routes these pins to the port in serial mode. */
`timescale 1ns/1ns
`default_nettype none
module mhap_host_model (
  output logic sck,  // serial clock, still low between frames
  output logic mosi, // serial data to the port
  output logic ss_b, // slave select, active low
  input  wire logic miso // serial data from the port, pulled high when released
);
  logic [23:0] got; // last three bytes seen on the serial output
  initial begin
    sck = 1'b0;
    mosi = 1'b1;
    ss_b = 1'b1;
  end
  // whole bytes msb first, data set while clock low
  // 320 ns period keeps the clock well under half the reference
  task automatic frame(input logic [7:0] b[$]);
    ss_b = 1'b0;
    #200;
    foreach (b[i]) for (int k = 7; k >= 0; k--) begin
      mosi = b[i][k];
      #160 sck = 1'b1;
      got = {got[22:0], miso}; // sampled on the rising serial clock
      #160 sck = 1'b0;
    end
    #400 mosi = ~mosi; // released line must not echo the last bit
    ss_b = 1'b1;
    #2000;
  endtask : frame
endmodule : mhap_host_model
`default_nettype wire

// ---- tb/tb_top.sv ----
/* Self-checking bench of the host access port, parallel then serial.
   Assumes four axes and device number 1 on the serial link. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        clk, rst_b, cs_b, wr_b, rd_b, ser, wait_request_n, sm, doe, moe, clr, si_c, si_v, si_s;
  logic [15:0] rs;
  logic [3:0]  addr_i, cs_c, cs_s, rw_c, rw_s;
  logic [7:0]  pd, d_o, cd_c, cd_s, b, si_dc, si_d;
  logic [23:0] w, v;
  logic [31:0] ms;
  logic [95:0] rv, rwd;
  logic [9:0]  tv[4] = '{10'h101, 10'h155, 10'h1ff, 10'h2f0};
  int          failures, compares, cyc, stalls, s0, seed = 32'h0bb8;
  wire         sck, mosi, ss_b;
  wire         miso = moe ? wait_request_n : 1'b1; // pull-up while the port lets go
  wire  [7:0]  d_i = {ser ? {mosi, sck} : pd[7:6], pd[5:0]};
  mhap_host_model host (.sck, .mosi, .ss_b, .miso);
  mhap_top dut (.clk, .rst_b, .cs_b(ser ? ss_b : cs_b), .wr_b, .rd_b, .addr_i,
    .d_i, .d_o, .d_oe(doe), .wrq_miso_o(wait_request_n), .wrq_miso_oe(moe), .serial_mode(sm),
    .cmd_stb_o(cs_c), .cmd_dat_o(cd_c), .reg_sel_o(rs), .reg_wr_stb_o(rw_c),
    .reg_wr_dat_o(rwd), .si_wr_stb_o(si_c), .si_wr_sel_o(si_v), .si_wr_dat_o(si_dc),
    .main_status_i(ms), .reg_val_i(rv));
  initial begin clk = 1'b0; forever #20 clk = ~clk; end
  // strobe catcher and stall count; strobes last one cycle only
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!wait_request_n && !ser) stalls <= stalls + 1;
    if (|cs_c) {cs_s, cd_s} <= {cs_c, cd_c};
    else if (clr) cs_s <= 4'h0;
    if (si_c) {si_s, si_d} <= {si_v, si_dc};
    if (|rw_c) rw_s <= rw_c;
    if (cyc == 20000) begin failures++; tally_and_finish(); end
  end
  task automatic chk(input logic [23:0] got, exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  task automatic do_reset(input logic s);
    {rst_b, ser, wr_b, rd_b, cs_b, addr_i} = {1'b0, s, ~s, ~s, 5'h11};
    repeat (20) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (6) @(posedge clk);
    #1;
  endtask : do_reset
  // write taken at the end of the strobe
  task automatic pw(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) #1 {cs_b, wr_b, addr_i, pd} = {2'b00, a, d};
    repeat (3) @(posedge clk);
    #1 wr_b = 1'b1;
    @(posedge clk) #1 cs_b = 1'b1;
  endtask : pw
  task automatic pr(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk) #1 {cs_b, rd_b, addr_i} = {2'b00, a};
    repeat (9) @(posedge clk); // covers sync and the four busy cycles
    #1 chk({doe, d_o}, {1'b1, e});
    {cs_b, rd_b} = 2'b11;
  endtask : pr
  initial begin
    ms = $random(seed);
    rv = {$random(seed), $random(seed), $random(seed)};
    do_reset(1'b0);
    chk(sm, 1'b0);
    for (int x = 0; x < 4; x++) begin
      {b, w} = {$random(seed)};
      pw({x[1:0], 2'h0}, b);
      repeat (8) @(posedge clk); // spacing for hosts without wait
      chk({cs_s, cd_s}, {4'h1 << x, b});
      pw({x[1:0], 2'h3}, w[23:16]);
      pw({x[1:0], 2'h2}, w[15:8]);
      pw({x[1:0], 2'h1}, w[7:0]);
      repeat (8) @(posedge clk);
      chk({rw_s, rwd[x*24+:24]}, {4'h1 << x, w});
      pr({x[1:0], 2'h0}, ms[x*8+:8]);
      for (int k = 1; k < 4; k++) pr({x[1:0], k[1:0]}, rv[x*24+k*8-8+:8]);
    end
    s0 = stalls;
    pw(4'h0, 8'hb2);
    pw(4'h2, 8'h5a);
    chk(stalls == s0, 1'b1);
    chk(rs[3:0], 4'h2);
    pw(4'h0, 8'h20);
    pr(4'h0, ms[7:0]);
    chk(stalls > s0, 1'b1);
    do_reset(1'b1);
    chk(sm, 1'b1);
    foreach (tv[i]) begin
      b = {4'h1, 4'($random(seed))};
      host.frame('{{tv[i][9:8], 2'b00, tv[i][7:4]}, b});
      chk(cs_s, tv[i][3:0]);
      if (|tv[i][3:0]) chk(cd_s, b);
      clr = 1'b1;
      #40 clr = 1'b0;
    end
    {w, v} = {$random(seed), $random(seed)};
    // two axes, full words in ascending axis order
    host.frame('{8'h45, 8'hb3, w[7:0], w[15:8], w[23:16], v[7:0], v[15:8], v[23:16]});
    chk(rw_s, 4'h5);
    chk(rwd[23:0], w);
    chk(rwd[71:48], v);
    chk(rs[11:8], 4'h3);
    // main status of the second axis, then a general read of the first
    host.frame('{8'h72, 8'h00});
    chk(host.got[7:0], ms[15:8]);
    host.frame('{8'h51, 8'h80, 8'h00, 8'h00, 8'h00});
    chk(host.got, {rv[7:0], rv[15:8], rv[23:16]});
    // single-instance write: axis bits ignored, fourth byte discarded
    b = 8'($random(seed));
    clr = 1'b1;
    #40 clr = 1'b0;
    host.frame('{8'h4a, 8'hbe, b, ~b});
    chk({cs_s, si_s, si_d}, {5'h00, b});
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
